/* File: charge_seq_regs.svh */
// timing counts and output codes for the charge sequencer
// assumes a 40 MHz mclk; included by the sequencer module only
// How it works
// - sense above 0.6 of supply means battery removed; charging stops
// - sense below 0.2 of supply means battery removed; charging stops
// - qualification ends once sense reaches the 0.34 level
// - conditioning current is one fifth of maximum current
// - every algorithm starts at conditioning current, pending until qualified
// - pending phase flashes status outputs zero and three
// - three-step: max or boosted current until bulk level
// - three-step: hold bulk voltage until current under a tenth of max
// - three-step: hold float voltage for ever
// - current mode: max or boosted current until bulk, or negative second difference while over the 2v level
// - current mode upkeep: fixed pulses of conditioning current, mean 0.1 max
// - pulsed mode: max or boosted current until bulk level
// - pulsed upkeep: off until float, then max or boosted until bulk, repeating
// - thermistor under 0.12 of supply blocks charging
// - after hot cutoff, charging waits until thermistor reaches 0.15
// - thermistor over 0.35 of supply blocks charging
// - battery present only between cutoffs, else fault state unless idle
// - abrupt battery voltage change may enter fault state
// - excess current, no charge taken, or selection change flag a fault
`ifndef CHARGE_SEQ_REGS_SVH
`define CHARGE_SEQ_REGS_SVH
`define MCLK_KHZ         40000
`define PEND_TIME_MS     1000
`define PEND_CYCLES      (`PEND_TIME_MS * `MCLK_KHZ)
`define FLASH_TIME_MS    250
`define FLASH_CYCLES     (`FLASH_TIME_MS * `MCLK_KHZ)
`define PULSE_TIME_MS    10
`define PULSE_CYCLES     (`PULSE_TIME_MS * `MCLK_KHZ)
`define COND_DIV         5
`define MIN_DIV          10
`define LVL_OFF          2'h0
`define LVL_COND         2'h1
`define LVL_MAX          2'h2
`define LVL_BOOST        2'h3
`define VREG_NONE        2'h0
`define VREG_BULK        2'h1
`define VREG_FLOAT       2'h2
`define ALGO_OFF         2'h0
`define ALGO_STEP3       2'h1
`define ALGO_CURRENT     2'h2
`define ALGO_PULSED      2'h3
`define FLAG_COUNT       14
`endif

/* File: charge_seq_pkg.sv */
// types shared by the charge sequencer files
// assumes charge_seq_regs.svh for the numeric codes
package charge_seq_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_PEND  = 8'h02,
    ST_FAST  = 8'h04,
    ST_BULK  = 8'h08,
    ST_FLOAT = 8'h10,
    ST_PULSE = 8'h20,
    ST_REST  = 8'h40,
    ST_FAULT = 8'h80
  } phase_e;
endpackage : charge_seq_pkg

/* File: flag_sync.sv */
// three-stage synchroniser for asynchronous comparator and pin levels
// assumes mclk domain; a bit changes once stages two and three agree
`timescale 1ns/1ps
module flag_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] nxt_clean;

  // s1 feeds only s2; agreement rejects a single-cycle glitch
  assign nxt_clean = (s2_ff & s3_ff) | (clean & (s2_ff | s3_ff));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      clean <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      clean <= nxt_clean;
    end
  end

  generate
    if (WIDTH < 1) begin : g_bad
      $error("flag_sync width must be positive");
    end
  endgenerate
endmodule : flag_sync

/* File: lead_acid_charge_sequencer.sv */
// charge phase sequencer for a sealed lead-acid charger
// assumes external comparators give one-bit threshold flags, asynchronous
`timescale 1ns/1ps
`include "charge_seq_regs.svh"
module lead_acid_charge_sequencer
  import charge_seq_pkg::*;
#(
  parameter int PEND_CYCLES  = `PEND_CYCLES,
  parameter int FLASH_CYCLES = `FLASH_CYCLES,
  parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic algo_select_low,
  input  wire logic algo_select_high,
  input  wire logic boost_n,
  input  wire logic bat_over_max,
  input  wire logic bat_under_min,
  input  wire logic bat_at_qual,
  input  wire logic bat_at_bulk,
  input  wire logic bat_under_float,
  input  wire logic bat_over_2v,
  input  wire logic second_diff_neg,
  input  wire logic bat_step,
  input  wire logic cur_under_min,
  input  wire logic cur_excess,
  input  wire logic therm_under_hot_cutoff,
  input  wire logic therm_over_hot_release,
  input  wire logic therm_over_cold_limit,
  output logic      switch_drive,
  output logic [1:0] current_level,
  output logic [1:0] voltage_reg,
  output logic      status_out_zero,
  output logic      status_out_one,
  output logic      status_out_two,
  output logic      status_out_three,
  output logic      fault_flag
);
  localparam int PERIOD_CYCLES = PULSE_CYCLES * `MIN_DIV / `COND_DIV;

  logic [`FLAG_COUNT-1:0] raw_flags;
  logic [`FLAG_COUNT-1:0] sync_flags;
  logic       sel_lo;
  logic       sel_hi;
  logic       boost_n_s;
  logic       over_max;
  logic       under_min;
  logic       at_qual;
  logic       at_bulk;
  logic       under_float;
  logic       over_2v;
  logic       sdiff_neg;
  logic       step;
  logic       cur_low;
  logic       cur_high;
  logic       hot_cut;
  logic       hot_rel;
  logic       cold;

  phase_e     state_ff;
  phase_e     nxt_state;
  logic [1:0] algo_ff;
  logic       present_ff;
  logic       hot_lock_ff;
  logic       nxt_hot_lock;
  logic [31:0] pend_cnt_ff;
  logic [31:0] flash_cnt_ff;
  logic       flash_ff;
  logic [31:0] pulse_cnt_ff;

  logic [1:0] algo;
  logic       present;
  logic       inserted;
  logic       sel_change;
  logic       temp_ok;
  logic       nxt_temp_ok;
  logic       pend_timeout;
  logic       fault_evt;
  logic       fast_done;
  logic       pulse_on;
  logic [1:0] fast_level;
  logic [1:0] nxt_level;
  logic [1:0] nxt_vreg;
  logic       nxt_drive;
  logic       pend_w;
  logic       charge_w;
  logic       upkeep_w;
  logic       fault_w;

  assign raw_flags = {algo_select_high, algo_select_low, boost_n,
                      bat_over_max, bat_under_min, bat_at_qual,
                      bat_at_bulk, bat_under_float, bat_over_2v,
                      second_diff_neg, bat_step, cur_under_min,
                      cur_excess, therm_under_hot_cutoff};

  flag_sync #(.WIDTH(`FLAG_COUNT)) u_sync_a (
    .mclk  (mclk),
    .rst_n (rst_n),
    .raw   (raw_flags),
    .clean (sync_flags)
  );

  flag_sync #(.WIDTH(2)) u_sync_b (
    .mclk  (mclk),
    .rst_n (rst_n),
    .raw   ({therm_over_hot_release, therm_over_cold_limit}),
    .clean ({hot_rel, cold})
  );

  assign {sel_hi, sel_lo, boost_n_s, over_max, under_min, at_qual,
          at_bulk, under_float, over_2v, sdiff_neg, step, cur_low,
          cur_high, hot_cut} = sync_flags;

  // decode
  assign algo       = {sel_hi, sel_lo};
  assign present    = !over_max && !under_min;
  assign inserted   = present && !present_ff;
  assign sel_change = (algo != algo_ff) && (state_ff != ST_IDLE);
  // hot lock released only at the higher hysteresis level
  assign nxt_hot_lock = hot_cut ? 1'b1 :
                        (hot_rel ? 1'b0 : hot_lock_ff);
  assign temp_ok     = !hot_lock_ff && !cold;
  assign nxt_temp_ok = !nxt_hot_lock && !cold;
  assign pend_timeout = (pend_cnt_ff >= 32'(PEND_CYCLES - 1));
  assign fault_evt = (state_ff != ST_IDLE) &&
                     (!present || step || cur_high || sel_change ||
                      (state_ff == ST_PEND && pend_timeout));
  assign fast_done = at_bulk ||
                     ((algo == `ALGO_CURRENT) && sdiff_neg && over_2v);
  assign pulse_on  = (pulse_cnt_ff < 32'(PULSE_CYCLES));
  assign fast_level = boost_n_s ? `LVL_MAX : `LVL_BOOST;

  always_comb begin
    nxt_state = state_ff;
    if (algo == `ALGO_OFF) begin
      nxt_state = ST_IDLE;
    end else if (fault_evt) begin
      nxt_state = ST_FAULT;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (present) nxt_state = ST_PEND;
        end
        ST_FAULT: begin
          if (inserted) nxt_state = ST_PEND;
        end
        ST_PEND: begin
          if (at_qual) nxt_state = ST_FAST;
        end
        ST_FAST: begin
          if (algo == `ALGO_STEP3 && at_bulk) begin
            nxt_state = ST_BULK;
          end else if (algo == `ALGO_CURRENT && fast_done) begin
            nxt_state = ST_PULSE;
          end else if (algo == `ALGO_PULSED && at_bulk) begin
            nxt_state = ST_REST;
          end
        end
        ST_BULK: begin
          if (cur_low) nxt_state = ST_FLOAT;
        end
        ST_FLOAT: nxt_state = ST_FLOAT;
        ST_PULSE: nxt_state = ST_PULSE;
        ST_REST: begin
          if (under_float) nxt_state = ST_FAST;
        end
        default: nxt_state = ST_FAULT;
      endcase
    end
  end

  // drive levels follow the phase being entered
  assign nxt_level =
    (nxt_state == ST_PEND)  ? `LVL_COND :
    (nxt_state == ST_FAST)  ? fast_level :
    (nxt_state == ST_BULK)  ? fast_level :
    (nxt_state == ST_FLOAT) ? `LVL_MAX :
    (nxt_state == ST_PULSE && pulse_on) ? `LVL_COND :
    `LVL_OFF;
  assign nxt_vreg =
    (nxt_state == ST_BULK)  ? `VREG_BULK :
    (nxt_state == ST_FLOAT) ? `VREG_FLOAT :
    `VREG_NONE;
  // the phase keeps running while too hot or cold; only the switch and the pending timer stop
  assign nxt_drive = nxt_temp_ok && (nxt_level != `LVL_OFF);
  assign pend_w    = (nxt_state == ST_PEND);
  assign charge_w  = (nxt_state == ST_FAST) || (nxt_state == ST_BULK);
  assign upkeep_w  = (nxt_state == ST_FLOAT) || (nxt_state == ST_PULSE) ||
                     (nxt_state == ST_REST);
  assign fault_w   = (nxt_state == ST_FAULT);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      algo_ff     <= `ALGO_OFF;
      present_ff  <= 1'b0;
      hot_lock_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      algo_ff     <= algo;
      present_ff  <= present;
      hot_lock_ff <= nxt_hot_lock;
    end
  end

  // pending timer pauses while temperature blocks charging
  always_ff @(posedge mclk) begin
    if (!rst_n || state_ff != ST_PEND) begin
      pend_cnt_ff <= '0;
    end else if (temp_ok && !pend_timeout) begin
      pend_cnt_ff <= pend_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flash_cnt_ff <= '0;
      flash_ff     <= 1'b0;
    end else if (flash_cnt_ff >= 32'(FLASH_CYCLES - 1)) begin
      flash_cnt_ff <= '0;
      flash_ff     <= !flash_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h1;
    end
  end

  // counter follows the phase being entered, so the first pulse is full width
  always_ff @(posedge mclk) begin
    if (!rst_n || nxt_state != ST_PULSE) begin
      pulse_cnt_ff <= '0;
    end else if (pulse_cnt_ff >= 32'(PERIOD_CYCLES - 1)) begin
      pulse_cnt_ff <= '0;
    end else begin
      pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      switch_drive     <= 1'b0;
      current_level    <= `LVL_OFF;
      voltage_reg      <= `VREG_NONE;
      status_out_zero  <= 1'b0;
      status_out_one   <= 1'b0;
      status_out_two   <= 1'b0;
      status_out_three <= 1'b0;
      fault_flag       <= 1'b0;
    end else begin
      switch_drive     <= nxt_drive;
      current_level    <= nxt_level;
      voltage_reg      <= nxt_vreg;
      status_out_zero  <= (pend_w && flash_ff) || fault_w;
      status_out_one   <= charge_w || (!nxt_temp_ok && flash_ff);
      status_out_two   <= upkeep_w;
      status_out_three <= (pend_w && flash_ff) || fault_w;
      fault_flag       <= fault_w;
    end
  end

  generate
    if (PEND_CYCLES < 1 || FLASH_CYCLES < 1 || PULSE_CYCLES < 1) begin : g_bad
      $error("sequencer cycle counts must be at least one");
    end
  endgenerate

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_qual_ready;
    state_ff == ST_PEND && at_qual && present && !fault_evt
      && algo != `ALGO_OFF;
  endsequence

  property p_absent_fault;
    !present && state_ff != ST_IDLE && algo != `ALGO_OFF
      |=> state_ff == ST_FAULT ##0 !switch_drive;
  endproperty
  a_absent_fault: assert property (p_absent_fault)
    else $error("absent battery did not reach fault");

  property p_absent_off;
    !present |=> !switch_drive;
  endproperty
  a_absent_off: assert property (p_absent_off)
    else $error("switch on with battery absent");

  property p_qual_exit;
    s_qual_ready |=> state_ff == ST_FAST ##0 current_level != `LVL_COND;
  endproperty
  a_qual_exit: assert property (p_qual_exit)
    else $error("qualification did not end at level");

  property p_pend_cond;
    state_ff == ST_PEND |-> current_level == `LVL_COND
      && status_out_zero == status_out_three;
  endproperty
  a_pend_cond: assert property (p_pend_cond)
    else $error("pending phase level or flash wrong");

  property p_boost;
    state_ff == ST_FAST && $past(nxt_state) == ST_FAST
      && $past(boost_n_s) == 1'b0 |-> current_level == `LVL_BOOST;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost pin low did not raise level");

  property p_hot_hold;
    hot_lock_ff && !hot_rel |=> hot_lock_ff ##0 !switch_drive;
  endproperty
  a_hot_hold: assert property (p_hot_hold)
    else $error("hot lock released early");

  property p_cold_off;
    cold |=> !switch_drive;
  endproperty
  a_cold_off: assert property (p_cold_off)
    else $error("switch on while cold");

  property p_sel_change;
    state_ff != ST_IDLE && algo != algo_ff && algo != `ALGO_OFF
      |=> state_ff == ST_FAULT ##1 state_ff != ST_FAST;
  endproperty
  a_sel_change: assert property (p_sel_change)
    else $error("selection change not faulted");

  property p_bulk_float;
    state_ff == ST_BULK && cur_low && !fault_evt && algo != `ALGO_OFF
      |=> state_ff == ST_FLOAT ##0 voltage_reg == `VREG_FLOAT;
  endproperty
  a_bulk_float: assert property (p_bulk_float)
    else $error("bulk hold did not move to float");

  property p_rest_off;
    state_ff == ST_REST |-> current_level == `LVL_OFF && !switch_drive;
  endproperty
  a_rest_off: assert property (p_rest_off)
    else $error("current flows in rest phase");
endmodule : lead_acid_charge_sequencer

/* File: battery_model.sv */
// partner model: battery pack, thermistor divider and current sense
// assumes the bench sets levels in thousandths of supply or of max current
`timescale 1ns/1ps
module battery_model #(
  parameter int BULK_MILLI  = 500,
  parameter int FLOAT_MILLI = 450,
  parameter int V2_MILLI    = 400
) (
  input  wire logic [9:0]  bat_milli,
  input  wire logic [9:0]  therm_milli,
  input  wire logic [10:0] cur_milli,
  output logic             bat_over_max,
  output logic             bat_under_min,
  output logic             bat_at_qual,
  output logic             bat_at_bulk,
  output logic             bat_under_float,
  output logic             bat_over_2v,
  output logic             cur_under_min,
  output logic             cur_excess,
  output logic             therm_under_hot_cutoff,
  output logic             therm_over_hot_release,
  output logic             therm_over_cold_limit
);
  // comparators are ideal; no noise near a threshold
  assign bat_over_max           = bat_milli > 10'h258;
  assign bat_under_min          = bat_milli < 10'hc8;
  assign bat_at_qual            = bat_milli >= 10'h154;
  assign bat_at_bulk            = bat_milli >= BULK_MILLI;
  assign bat_under_float        = bat_milli <= FLOAT_MILLI;
  assign bat_over_2v            = bat_milli > V2_MILLI;
  assign cur_under_min          = cur_milli < 11'h64;
  assign cur_excess             = cur_milli > 11'h5dc;
  assign therm_under_hot_cutoff = therm_milli < 10'h78;
  assign therm_over_hot_release = therm_milli >= 10'h96;
  assign therm_over_cold_limit  = therm_milli > 10'h15e;
endmodule : battery_model

/* File: lead_acid_charge_sequencer_tb_top.sv */
// self-checking bench for the charge sequencer with a battery model
// assumes flags settle within eight cycles of a pin change
`timescale 1ns/1ps
module lead_acid_charge_sequencer_tb_top;
  localparam int PEND = 200;
  localparam int FLASH = 4;
  localparam int PULSE = 3;
  logic mclk = 0, rst_n = 0, sel_lo = 0, sel_hi = 0, boost_n = 1;
  logic sdn = 0, step = 0;
  logic [9:0] bat = 10'h12c, therm = 10'hfa;
  logic [10:0] cur = 11'h3e8;
  logic ovm, unm, qual, bulk, unf, o2v, cmin, cex, hot, hrel, cold;
  logic switch_drive, s0, s1, s2, s3, fault_flag;
  logic [1:0] current_level, voltage_reg;
  int n_errors = 0, compares = 0;

  initial forever #12.5 mclk = ~mclk;

  battery_model i_model (.bat_milli(bat), .therm_milli(therm),
    .cur_milli(cur), .bat_over_max(ovm), .bat_under_min(unm),
    .bat_at_qual(qual), .bat_at_bulk(bulk), .bat_under_float(unf),
    .bat_over_2v(o2v), .cur_under_min(cmin), .cur_excess(cex),
    .therm_under_hot_cutoff(hot), .therm_over_hot_release(hrel),
    .therm_over_cold_limit(cold));

  lead_acid_charge_sequencer #(.PEND_CYCLES(PEND), .FLASH_CYCLES(FLASH),
    .PULSE_CYCLES(PULSE)) i_dut (.mclk(mclk), .rst_n(rst_n),
    .algo_select_low(sel_lo), .algo_select_high(sel_hi),
    .boost_n(boost_n), .bat_over_max(ovm), .bat_under_min(unm),
    .bat_at_qual(qual), .bat_at_bulk(bulk), .bat_under_float(unf),
    .bat_over_2v(o2v), .second_diff_neg(sdn), .bat_step(step),
    .cur_under_min(cmin), .cur_excess(cex),
    .therm_under_hot_cutoff(hot), .therm_over_hot_release(hrel),
    .therm_over_cold_limit(cold), .switch_drive(switch_drive),
    .current_level(current_level), .voltage_reg(voltage_reg),
    .status_out_zero(s0), .status_out_one(s1), .status_out_two(s2),
    .status_out_three(s3), .fault_flag(fault_flag));

  task automatic chk(input string what, input logic [1:0] exp,
                     input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // reset held six cycles, switch_drive must be off at its end
  task automatic do_reset(input logic hi, input logic lo);
    rst_n = 0;
    sel_hi = hi;
    sel_lo = lo;
    bat = 10'h12c;
    cyc(6);
    chk("switch_drive", 2'h0, {1'b0, switch_drive});
    rst_n = 1;
    cyc(8);
  endtask : do_reset

  task automatic flash_chk;
    int t;
    logic p;
    t = 0;
    p = s0;
    repeat (4 * FLASH) begin
      cyc(1);
      if (s0 !== p) t++;
      p = s0;
      chk("status_out_three", {1'b0, s0}, {1'b0, s3});
    end
    chk("flash_toggles", 2'h1, {1'b0, t == 4});
  endtask : flash_chk

  task automatic t_three_step;
    do_reset(0, 1);
    chk("current_level", 2'h1, current_level);
    chk("switch_drive", 2'h1, {1'b0, switch_drive});
    flash_chk();
    bat = 10'h190;
    cyc(8);
    chk("current_level", 2'h2, current_level);
    chk("voltage_reg", 2'h0, voltage_reg);
    chk("status_out_one", 2'h1, {1'b0, s1});
    bat = 10'h208;
    cyc(8);
    chk("voltage_reg", 2'h1, voltage_reg);
    cur = 11'h32;
    cyc(8);
    chk("voltage_reg", 2'h2, voltage_reg);
    chk("status_out_two", 2'h1, {1'b0, s2});
    therm = 10'h64;
    cyc(8);
    chk("switch_drive", 2'h0, {1'b0, switch_drive});
    therm = 10'h82;
    cyc(8);
    chk("switch_drive", 2'h0, {1'b0, switch_drive});
    therm = 10'hc8;
    cyc(8);
    chk("switch_drive", 2'h1, {1'b0, switch_drive});
    therm = 10'h190;
    cyc(8);
    chk("switch_drive", 2'h0, {1'b0, switch_drive});
    therm = 10'hfa;
    cur = 11'h3e8;
  endtask : t_three_step

  task automatic t_pulsed;
    boost_n = 0;
    do_reset(1, 1);
    chk("current_level", 2'h1, current_level);
    bat = 10'h190;
    cyc(8);
    chk("current_level", 2'h3, current_level);
    bat = 10'h208;
    cyc(8);
    chk("current_level", 2'h0, current_level);
    bat = 10'h1d6;
    cyc(8);
    chk("current_level", 2'h0, current_level);
    bat = 10'h1b8;
    cyc(8);
    chk("current_level", 2'h3, current_level);
    boost_n = 1;
  endtask : t_pulsed

  task automatic t_current;
    int on, off;
    do_reset(1, 0);
    bat = 10'h17c;
    cyc(8);
    chk("current_level", 2'h2, current_level);
    sdn = 1;
    cyc(8);
    chk("current_level", 2'h2, current_level);
    bat = 10'h1c2;
    cyc(8);
    on = 0;
    off = 0;
    repeat (8 * PULSE) begin
      cyc(1);
      if (current_level === 2'h1) on++;
      if (current_level === 2'h0) off++;
    end
    chk("pulse_on", 2'h1, {1'b0, on == 4 * PULSE});
    chk("pulse_off", 2'h1, {1'b0, off == 4 * PULSE});
    sdn = 0;
  endtask : t_current

  task automatic reinsert;
    bat = 10'h2bc;
    cyc(8);
    bat = 10'h12c;
    cyc(8);
  endtask : reinsert

  task automatic t_faults;
    do_reset(0, 1);
    cyc(PEND + 20);
    chk("fault_flag", 2'h1, {1'b0, fault_flag});
    chk("status_out_zero", 2'h1, {1'b0, s0});
    chk("status_out_three", 2'h1, {1'b0, s3});
    reinsert();
    chk("fault_flag", 2'h0, {1'b0, fault_flag});
    chk("current_level", 2'h1, current_level);
    bat = 10'h2bc;
    cyc(8);
    chk("fault_flag", 2'h1, {1'b0, fault_flag});
    chk("switch_drive", 2'h0, {1'b0, switch_drive});
    bat = 10'h12c;
    cyc(8);
    bat = 10'h64;
    cyc(8);
    chk("fault_flag", 2'h1, {1'b0, fault_flag});
    bat = 10'h12c;
    cyc(8);
    step = 1;
    cyc(8);
    chk("fault_flag", 2'h1, {1'b0, fault_flag});
    step = 0;
    reinsert();
    cur = 11'h640;
    cyc(8);
    chk("fault_flag", 2'h1, {1'b0, fault_flag});
    cur = 11'h3e8;
    reinsert();
    sel_hi = 1;
    cyc(8);
    chk("fault_flag", 2'h1, {1'b0, fault_flag});
    sel_hi = 0;
    sel_lo = 0;
    cyc(8);
    chk("fault_flag", 2'h0, {1'b0, fault_flag});
    chk("current_level", 2'h0, current_level);
    chk("switch_drive", 2'h0, {1'b0, switch_drive});
  endtask : t_faults

  // full run is a few hundred cycles; far more means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    results();
  end

  initial begin
    t_three_step();
    t_pulsed();
    t_current();
    t_faults();
    results();
  end
endmodule : lead_acid_charge_sequencer_tb_top
